// File: common/gpio_pkg.sv
// Package with the register map, field layouts, drive modes and sizes of the GPIO port block.
package gpio_pkg;

  localparam int NUM_PORTS  = 4;
  localparam int PORT_WIDTH = 8;
  localparam int NUM_PINS   = NUM_PORTS * PORT_WIDTH;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // Address layout: bits [5:4] pick the port, bits [3:0] pick the register.
  localparam int PORT_SEL_LSB = 4;
  localparam int PORT_SEL_W   = 2;
  localparam int REG_SEL_W    = 4;

  localparam logic [REG_SEL_W-1:0] REG_OUT_DATA    = 4'h0;
  localparam logic [REG_SEL_W-1:0] REG_PIN_STATE   = 4'h1;
  localparam logic [REG_SEL_W-1:0] REG_DRIVE_MODE  = 4'h2;
  localparam logic [REG_SEL_W-1:0] REG_THRESHOLD   = 4'h3;
  localparam logic [REG_SEL_W-1:0] REG_IN_BUF_EN   = 4'h4;
  localparam logic [REG_SEL_W-1:0] REG_OUT_BUF_EN  = 4'h5;
  localparam logic [REG_SEL_W-1:0] REG_SLEW        = 4'h6;
  localparam logic [REG_SEL_W-1:0] REG_MUX_SEL     = 4'h7;
  localparam logic [REG_SEL_W-1:0] REG_INTR_STATUS = 4'h8;
  localparam logic [REG_SEL_W-1:0] REG_INTR_MASK   = 4'h9;
  localparam logic [REG_SEL_W-1:0] REG_LUT_IN      = 4'ha;
  localparam logic [REG_SEL_W-1:0] REG_LUT_OUT     = 4'hb;
  localparam logic [REG_SEL_W-1:0] REG_LUT_EN      = 4'hc;

  // Field widths inside a port's registers.
  localparam int MODE_W    = 3;
  localparam int MUX_W     = 2;
  localparam int LUT_W     = 4;
  localparam int LUT_EN_IN_LSB  = 0;
  localparam int LUT_EN_OUT_LSB = 8;

  // Reset values: every buffer disabled, every pin analog, all routing to the data register.
  localparam logic [PORT_WIDTH-1:0]        RST_BYTE  = 8'h00;
  localparam logic [MODE_W*PORT_WIDTH-1:0] RST_MODE  = 24'h000000;
  localparam logic [MUX_W*PORT_WIDTH-1:0]  RST_MUX   = 16'h0000;
  localparam logic [LUT_W*PORT_WIDTH-1:0]  RST_LUT   = 32'h00000000;
  localparam logic [DATA_W-1:0]            RST_WORD  = 32'h00000000;

  // Default implemented-pin masks; ports 2 and 3 carry fewer pins.
  localparam logic [PORT_WIDTH-1:0] PINS_PORT0 = 8'hff;
  localparam logic [PORT_WIDTH-1:0] PINS_PORT1 = 8'hff;
  localparam logic [PORT_WIDTH-1:0] PINS_PORT2 = 8'h3f;
  localparam logic [PORT_WIDTH-1:0] PINS_PORT3 = 8'h0f;

  typedef enum logic [MODE_W-1:0] {
    GPIO_MODE_ANALOG     = 3'h0,
    GPIO_MODE_INPUT_ONLY = 3'h1,
    GPIO_MODE_WEAKUP_STRONGDN = 3'h2,
    GPIO_MODE_STRONGUP_WEAKDN = 3'h3,
    GPIO_MODE_OPEN_DRAIN_LO   = 3'h4,
    GPIO_MODE_OPEN_DRAIN_HI   = 3'h5,
    GPIO_MODE_STRONG     = 3'h6,
    GPIO_MODE_WEAK       = 3'h7
  } gpio_mode_t;

  // Threshold select: 0 picks CMOS levels, 1 picks low_voltage_ttl_threshold.
  localparam logic THRESH_CMOS = 1'b0;
  localparam logic THRESH_LOW_VOLTAGE_TTL = 1'b1;

endpackage

// File: rtl/gpio_port_top.sv
// GPIO port block: pin drive, input sensing, routing, lookup fabric, interrupts and register port.
`timescale 1ns/1ps

// Overview of operation
// RQ1: Eight selectable drive modes per pin.
// RQ2: Analog mode disables input and output buffers.
// RQ3: Per-pin CMOS or low-voltage TTL threshold.
// RQ4: Per-pin input and output buffer enables.
// RQ5: Per-pin slew rate selection.
// RQ6: Eight-bit ports, ports 2 and 3 narrower.
// RQ7: Reset forces every pin buffer disabled.
// RQ8: Matrix selects pin source and input route.
// RQ9: Output data and pin state registers.
// RQ10: Only enabled pins raise interrupts.
// RQ11: One level request line per port, four.
// RQ12: Lookup tables act on inbound and outbound signals.
// RQ13: Reset returns all configuration to defaults.
// RQ14: Flags stay until written one; set wins.
module gpio_port_top
  import gpio_pkg::*;
#(
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS0 = gpio_pkg::PINS_PORT0,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS1 = gpio_pkg::PINS_PORT1,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS2 = gpio_pkg::PINS_PORT2,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS3 = gpio_pkg::PINS_PORT3
)
(
  input  wire logic                            clk,
  input  wire logic                            srst,
  input  wire logic [gpio_pkg::ADDR_W-1:0]     addr,
  input  wire logic [gpio_pkg::DATA_W-1:0]     wdata,
  input  wire logic                            wr_stb,
  input  wire logic                            rd_stb,
  output logic      [gpio_pkg::DATA_W-1:0]     rdata,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]   pad_in,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_out,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_oe,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_weak_pu,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_weak_pd,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_in_buf_en,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_thresh_sel,
  output logic      [gpio_pkg::NUM_PINS-1:0]   pad_slow_slew,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]   periph_src_a,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]   periph_src_b,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]   periph_src_c,
  output logic      [gpio_pkg::NUM_PINS-1:0]   periph_in,
  output logic      [gpio_pkg::NUM_PORTS-1:0]  irq
);
  import gpio_pkg::*;

  localparam logic [NUM_PINS-1:0] PIN_MASK = {PINS3, PINS2, PINS1, PINS0}; // [RQ6]

  logic [PORT_WIDTH-1:0]        out_data_ff   [NUM_PORTS];
  logic [MODE_W*PORT_WIDTH-1:0] drive_mode_ff [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        thresh_ff     [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        in_en_ff      [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        out_en_ff     [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        slew_ff       [NUM_PORTS];
  logic [MUX_W*PORT_WIDTH-1:0]  mux_sel_ff    [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        int_stat_ff   [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        int_mask_ff   [NUM_PORTS];
  logic [LUT_W*PORT_WIDTH-1:0]  lut_in_ff     [NUM_PORTS];
  logic [LUT_W*PORT_WIDTH-1:0]  lut_out_ff    [NUM_PORTS];
  logic [2*PORT_WIDTH-1:0]      lut_en_ff     [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        pin_state_ff  [NUM_PORTS];
  logic [PORT_WIDTH-1:0]        pin_prev_ff   [NUM_PORTS];
  logic [DATA_W-1:0]            rdata_ff;
  logic [NUM_PORTS-1:0]         irq_ff;
  logic [NUM_PINS-1:0]          pad_out_ff;
  logic [NUM_PINS-1:0]          pad_oe_ff;
  logic [NUM_PINS-1:0]          weak_pu_ff;
  logic [NUM_PINS-1:0]          weak_pd_ff;
  logic [NUM_PINS-1:0]          in_buf_ff;
  logic [NUM_PINS-1:0]          thresh_out_ff;
  logic [NUM_PINS-1:0]          slew_out_ff;
  logic [NUM_PINS-1:0]          periph_in_ff;

  logic [PORT_SEL_W-1:0] port_sel;
  logic [REG_SEL_W-1:0]  reg_sel;
  logic                  addr_ok;

  assign port_sel = addr[PORT_SEL_LSB +: PORT_SEL_W];
  assign reg_sel  = addr[REG_SEL_W-1:0];
  assign addr_ok  = (addr[ADDR_W-1:PORT_SEL_LSB+PORT_SEL_W] == '0);

  // Returns {oe, out, weak_pu, weak_pd} for one pin from its mode and data bit.
  function automatic logic [3:0] drive_decode(input gpio_mode_t mode, input logic val);
    logic [3:0] r;
    r = 4'h0;
    unique case (mode)
      GPIO_MODE_ANALOG:          r = 4'h0;
      GPIO_MODE_INPUT_ONLY:      r = 4'h0;
      GPIO_MODE_WEAKUP_STRONGDN: r = val ? 4'h2 : 4'h8;
      GPIO_MODE_STRONGUP_WEAKDN: r = val ? 4'hc : 4'h1;
      GPIO_MODE_OPEN_DRAIN_LO:   r = val ? 4'h0 : 4'h8;
      GPIO_MODE_OPEN_DRAIN_HI:   r = val ? 4'hc : 4'h0;
      GPIO_MODE_STRONG:          r = val ? 4'hc : 4'h8;
      GPIO_MODE_WEAK:            r = val ? 4'h2 : 4'h1;
    endcase
    return r; // [RQ1]
  endfunction

  // Two-input lookup: a pin's own signal and its upper neighbour's select one of four table bits.
  function automatic logic [PORT_WIDTH-1:0] lut_apply(input logic [PORT_WIDTH-1:0] sig,
                                                      input logic [LUT_W*PORT_WIDTH-1:0] table_bits,
                                                      input logic [PORT_WIDTH-1:0] en);
    logic [PORT_WIDTH-1:0] r;
    logic [1:0]            idx;
    r = sig;
    for (int i = 0; i < PORT_WIDTH; i++)
    begin
      idx = {sig[(i+1)%PORT_WIDTH], sig[i]};
      if (en[i])
      begin
        r[i] = table_bits[i*LUT_W + int'(idx)];
      end
    end
    return r;
  endfunction

  // Per-pin routing: 0 takes the data register, 1 to 3 take a peripheral source.
  function automatic logic [PORT_WIDTH-1:0] mux_route(input int p,
                                                      input logic [MUX_W*PORT_WIDTH-1:0] sel,
                                                      input logic [PORT_WIDTH-1:0] data);
    logic [PORT_WIDTH-1:0] r;
    r = data;
    for (int i = 0; i < PORT_WIDTH; i++)
    begin
      unique case (sel[i*MUX_W +: MUX_W])
        2'h0: r[i] = data[i];
        2'h1: r[i] = periph_src_a[p*PORT_WIDTH+i];
        2'h2: r[i] = periph_src_b[p*PORT_WIDTH+i];
        2'h3: r[i] = periph_src_c[p*PORT_WIDTH+i];
      endcase
    end
    return r;
  endfunction

  // Configuration registers; writes store every bit, unimplemented pins included, and PIN_MASK gates them only at the pads.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        out_data_ff[p]   <= RST_BYTE; // [RQ13]
        drive_mode_ff[p] <= RST_MODE;
        thresh_ff[p]     <= RST_BYTE;
        in_en_ff[p]      <= RST_BYTE;
        out_en_ff[p]     <= RST_BYTE;
        slew_ff[p]       <= RST_BYTE;
        mux_sel_ff[p]    <= RST_MUX;
        int_mask_ff[p]   <= RST_BYTE;
        lut_in_ff[p]     <= RST_LUT;
        lut_out_ff[p]    <= RST_LUT;
        lut_en_ff[p]     <= '0;
      end
    end
    else if (wr_stb && addr_ok)
    begin
      unique case (reg_sel)
        REG_OUT_DATA:   out_data_ff[port_sel]   <= wdata[PORT_WIDTH-1:0]; // [RQ9]
        REG_DRIVE_MODE: drive_mode_ff[port_sel] <= wdata[MODE_W*PORT_WIDTH-1:0]; // [RQ1]
        REG_THRESHOLD:  thresh_ff[port_sel]     <= wdata[PORT_WIDTH-1:0]; // [RQ3]
        REG_IN_BUF_EN:  in_en_ff[port_sel]      <= wdata[PORT_WIDTH-1:0]; // [RQ4]
        REG_OUT_BUF_EN: out_en_ff[port_sel]     <= wdata[PORT_WIDTH-1:0]; // [RQ4]
        REG_SLEW:       slew_ff[port_sel]       <= wdata[PORT_WIDTH-1:0]; // [RQ5]
        REG_MUX_SEL:    mux_sel_ff[port_sel]    <= wdata[MUX_W*PORT_WIDTH-1:0]; // [RQ8]
        REG_INTR_MASK:  int_mask_ff[port_sel]   <= wdata[PORT_WIDTH-1:0]; // [RQ10]
        REG_LUT_IN:     lut_in_ff[port_sel]     <= wdata[LUT_W*PORT_WIDTH-1:0]; // [RQ12]
        REG_LUT_OUT:    lut_out_ff[port_sel]    <= wdata[LUT_W*PORT_WIDTH-1:0]; // [RQ12]
        REG_LUT_EN:     lut_en_ff[port_sel]     <= wdata[2*PORT_WIDTH-1:0]; // [RQ12]
        default:        ;
      endcase
    end
  end

  // Pin drive: mode decode after the outbound lookup, gated by output buffer enable and pin presence.
  always_ff @(posedge clk)
  begin
    logic [PORT_WIDTH-1:0] src;
    logic [3:0]            d;
    logic                  en;
    src = '0;
    d   = 4'h0;
    en  = 1'b0;
    if (srst)
    begin
      pad_out_ff    <= '0; // [RQ7]
      pad_oe_ff     <= '0; // [RQ7]
      weak_pu_ff    <= '0;
      weak_pd_ff    <= '0;
      in_buf_ff     <= '0; // [RQ7]
      thresh_out_ff <= '0;
      slew_out_ff   <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        src = mux_route(p, mux_sel_ff[p], out_data_ff[p]); // [RQ8]
        src = lut_apply(src, lut_out_ff[p], lut_en_ff[p][LUT_EN_OUT_LSB +: PORT_WIDTH]); // [RQ12]
        for (int i = 0; i < PORT_WIDTH; i++)
        begin
          d  = drive_decode(gpio_mode_t'(drive_mode_ff[p][i*MODE_W +: MODE_W]), src[i]); // [RQ1]
          en = out_en_ff[p][i] && PIN_MASK[p*PORT_WIDTH+i]; // [RQ4] [RQ6]
          pad_oe_ff[p*PORT_WIDTH+i]  <= d[3] && en; // [RQ2]
          pad_out_ff[p*PORT_WIDTH+i] <= d[2] && en;
          weak_pu_ff[p*PORT_WIDTH+i] <= d[1] && en;
          weak_pd_ff[p*PORT_WIDTH+i] <= d[0] && en;
          // Analog mode overrides the input enable so the digital input never loads an analog node.
          in_buf_ff[p*PORT_WIDTH+i] <= in_en_ff[p][i] && PIN_MASK[p*PORT_WIDTH+i]
                                       && (drive_mode_ff[p][i*MODE_W +: MODE_W] != GPIO_MODE_ANALOG); // [RQ2] [RQ4]
          thresh_out_ff[p*PORT_WIDTH+i] <= thresh_ff[p][i] && PIN_MASK[p*PORT_WIDTH+i]; // [RQ3]
          slew_out_ff[p*PORT_WIDTH+i]   <= slew_ff[p][i] && PIN_MASK[p*PORT_WIDTH+i]; // [RQ5]
        end
      end
    end
  end

  // Input sensing: pad levels pass the input buffer gate, then the inbound lookup.
  always_ff @(posedge clk)
  begin
    logic [PORT_WIDTH-1:0] raw;
    raw = '0;
    if (srst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        pin_state_ff[p] <= RST_BYTE;
        pin_prev_ff[p]  <= RST_BYTE;
      end
      periph_in_ff <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        raw = pad_in[p*PORT_WIDTH +: PORT_WIDTH] & in_buf_ff[p*PORT_WIDTH +: PORT_WIDTH];
        raw = lut_apply(raw, lut_in_ff[p], lut_en_ff[p][LUT_EN_IN_LSB +: PORT_WIDTH]); // [RQ12]
        pin_state_ff[p] <= raw & PIN_MASK[p*PORT_WIDTH +: PORT_WIDTH]; // [RQ9]
        pin_prev_ff[p]  <= pin_state_ff[p];
        for (int i = 0; i < PORT_WIDTH; i++)
        begin
          periph_in_ff[p*PORT_WIDTH+i] <= pin_state_ff[p][i]
                                          && (mux_sel_ff[p][i*MUX_W +: MUX_W] != 2'h0); // [RQ8]
        end
      end
    end
  end

  // Interrupt flags: any edge of an enabled pin sets its flag; set beats a same-cycle clear.
  always_ff @(posedge clk)
  begin
    logic [PORT_WIDTH-1:0] set_v;
    logic [PORT_WIDTH-1:0] clr_v;
    set_v = '0;
    clr_v = '0;
    if (srst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        int_stat_ff[p] <= RST_BYTE;
      end
      irq_ff <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        set_v = (pin_state_ff[p] ^ pin_prev_ff[p]) & int_mask_ff[p]; // [RQ10]
        clr_v = (wr_stb && addr_ok && reg_sel == REG_INTR_STATUS && port_sel == PORT_SEL_W'(p))
                ? wdata[PORT_WIDTH-1:0] : '0;
        int_stat_ff[p] <= (int_stat_ff[p] & ~clr_v) | set_v; // [RQ14]
        irq_ff[p]      <= |(((int_stat_ff[p] & ~clr_v) | set_v) & int_mask_ff[p]); // [RQ11] [RQ14]
      end
    end
  end

  // Register read port: data stand one cycle after the strobe, zero elsewhere.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_ff <= RST_WORD;
    end
    else if (rd_stb && addr_ok)
    begin
      unique case (reg_sel)
        REG_OUT_DATA:    rdata_ff <= DATA_W'(out_data_ff[port_sel]);
        REG_PIN_STATE:   rdata_ff <= DATA_W'(pin_state_ff[port_sel]); // [RQ9]
        REG_DRIVE_MODE:  rdata_ff <= DATA_W'(drive_mode_ff[port_sel]);
        REG_THRESHOLD:   rdata_ff <= DATA_W'(thresh_ff[port_sel]);
        REG_IN_BUF_EN:   rdata_ff <= DATA_W'(in_en_ff[port_sel]);
        REG_OUT_BUF_EN:  rdata_ff <= DATA_W'(out_en_ff[port_sel]);
        REG_SLEW:        rdata_ff <= DATA_W'(slew_ff[port_sel]);
        REG_MUX_SEL:     rdata_ff <= DATA_W'(mux_sel_ff[port_sel]);
        REG_INTR_STATUS: rdata_ff <= DATA_W'(int_stat_ff[port_sel]);
        REG_INTR_MASK:   rdata_ff <= DATA_W'(int_mask_ff[port_sel]);
        REG_LUT_IN:      rdata_ff <= DATA_W'(lut_in_ff[port_sel]);
        REG_LUT_OUT:     rdata_ff <= DATA_W'(lut_out_ff[port_sel]);
        REG_LUT_EN:      rdata_ff <= DATA_W'(lut_en_ff[port_sel]);
        default:         rdata_ff <= RST_WORD;
      endcase
    end
    else
    begin
      rdata_ff <= RST_WORD;
    end
  end

  assign rdata          = rdata_ff;
  assign irq            = irq_ff;
  assign pad_out        = pad_out_ff;
  assign pad_oe         = pad_oe_ff;
  assign pad_weak_pu    = weak_pu_ff;
  assign pad_weak_pd    = weak_pd_ff;
  assign pad_in_buf_en  = in_buf_ff;
  assign pad_thresh_sel = thresh_out_ff;
  assign pad_slow_slew  = slew_out_ff;
  assign periph_in      = periph_in_ff;

endmodule // gpio_port_top

// File: test/gpio_port_checker.sv
// Assertion checker for the GPIO port block, bound to its top module.
`timescale 1ns/1ps
module gpio_port_checker
  import gpio_pkg::*;
#(
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS0 = gpio_pkg::PINS_PORT0,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS1 = gpio_pkg::PINS_PORT1,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS2 = gpio_pkg::PINS_PORT2,
  parameter logic [gpio_pkg::PORT_WIDTH-1:0] PINS3 = gpio_pkg::PINS_PORT3
)
(
  input wire logic                           clk,
  input wire logic                           srst,
  input wire logic [gpio_pkg::ADDR_W-1:0]    addr,
  input wire logic [gpio_pkg::DATA_W-1:0]    wdata,
  input wire logic                           wr_stb,
  input wire logic                           rd_stb,
  input wire logic [gpio_pkg::DATA_W-1:0]    rdata,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  pad_out,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  pad_oe,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  pad_weak_pu,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  pad_weak_pd,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  pad_in_buf_en,
  input wire logic [gpio_pkg::NUM_PORTS-1:0] irq
);
  logic [NUM_PINS-1:0]  gone;
  logic [NUM_PINS-1:0]  act;
  logic [NUM_PINS-1:0]  drv;
  logic [NUM_PORTS-1:0] hit;

  assign gone = ~{PINS3, PINS2, PINS1, PINS0};
  assign act  = pad_oe | pad_in_buf_en | pad_weak_pu | pad_weak_pd;
  assign drv  = pad_oe | pad_out | pad_weak_pu | pad_weak_pd;

  // A status or mask write is the only legal way for a port request to drop.
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      hit[p] = wr_stb && addr[7:4] == 4'(p) && addr[3:1] == 3'h4;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence bad_rd_s;
    rd_stb && (addr[7:6] != 2'h0 || addr[3:0] > 4'hc);
  endsequence

  sequence obe_off_s;
    wr_stb && addr == 8'h05 && wdata[7:0] == 8'h00;
  endsequence

  // The request is registered: a status clear drops it at once, a mask write one cycle later.
  property irq_hold_p;
    1'b1 |=> (irq & $past(irq & ~hit) & ~$past(hit, 2)) == ($past(irq & ~hit) & ~$past(hit, 2));
  endproperty

  unmapped_read_a: assert property (bad_rd_s |=> rdata == '0)
    else $error("unmapped read returned data");
  rdata_idle_a: assert property (!rd_stb |=> rdata == '0)
    else $error("read data outside the read slot");
  reset_quiet_a: assert property ($fell(srst) |-> act == '0 && irq == '0)
    else $error("pin buffers active after reset");
  pull_excl_a: assert property (((pad_weak_pu & pad_weak_pd) | (pad_oe & (pad_weak_pu | pad_weak_pd))) == '0)
    else $error("conflicting drive on a pin");
  high_needs_oe_a: assert property ((pad_out & ~pad_oe) == '0)
    else $error("pad high without drive enable");
  unimpl_quiet_a: assert property ((act & gone) == '0)
    else $error("missing pin shows activity");
  irq_hold_a: assert property (irq_hold_p)
    else $error("port request dropped without a write");
  obe_off_a: assert property (obe_off_s |=> ##1 drv[7:0] == 8'h00)
    else $error("output buffers still active");
endmodule // gpio_port_checker

bind gpio_port_top gpio_port_checker #(.PINS0(PINS0), .PINS1(PINS1), .PINS2(PINS2), .PINS3(PINS3)) chk (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_weak_pu(pad_weak_pu), .pad_weak_pd(pad_weak_pd),
  .pad_in_buf_en(pad_in_buf_en), .irq(irq));

// File: test/gpio_board.sv
// Board model: resolves each pad from the block's drive, board drivers and pulls.
`timescale 1ns/1ps
module gpio_board
  import gpio_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pad_out,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pad_oe,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pad_weak_pu,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pad_weak_pd,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] ext_val,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] ext_en,
  output logic      [gpio_pkg::NUM_PINS-1:0] pad_in
);
  logic [NUM_PINS-1:0] last_ff;

  // A floating pad shows the inverse of its last level so a stale value never reads as a match.
  always_ff @(posedge clk)
    last_ff <= pad_in;

  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_weak_pu | (~pad_weak_pd & ~last_ff)));
endmodule // gpio_board

// File: test/gpio_port_with_pin_logic_tb.sv
// Self-checking testbench for the GPIO port block.
`timescale 1ns/1ps
module gpio_port_with_pin_logic_tb;
  import gpio_pkg::*;
  logic                 clk;
  logic                 srst = 1'b1;
  logic                 wr_stb = 1'b0;
  logic                 rd_stb = 1'b0;
  logic [ADDR_W-1:0]    addr = '0;
  logic [DATA_W-1:0]    wdata = '0;
  logic [DATA_W-1:0]    rdata;
  logic [NUM_PINS-1:0]  pad_in, pad_out, pad_oe, pu, pd, ibe, thr, slew, periph_in;
  logic [NUM_PINS-1:0]  src_a = '1;
  logic [NUM_PINS-1:0]  src_b = '0;
  logic [NUM_PINS-1:0]  ext_val = '0;
  logic [NUM_PINS-1:0]  ext_en = '1;
  logic [NUM_PORTS-1:0] irq;
  int                   n_mismatch = 0;
  int                   n_checks = 0;
  // Each row: mode, data bit, then expected {oe, out, pull up, pull down, input buffer}.
  logic [8:0] rows [16] = '{9'h000, 9'h020, 9'h041, 9'h061, 9'h091, 9'h0a5, 9'h0c3, 9'h0f9,
                            9'h111, 9'h121, 9'h141, 9'h179, 9'h191, 9'h1b9, 9'h1c3, 9'h1e5};

  gpio_port_top dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_weak_pu(pu), .pad_weak_pd(pd),
    .pad_in_buf_en(ibe), .pad_thresh_sel(thr), .pad_slow_slew(slew), .periph_src_a(src_a),
    .periph_src_b(src_b), .periph_src_c(src_a), .periph_in(periph_in), .irq(irq));
  gpio_board board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_weak_pu(pu), .pad_weak_pd(pd),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Strobes stay up across back-to-back writes; go() lowers them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask

  task automatic go(input int n);
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 ck("rdata", e, rdata);
  endtask

  function automatic logic [31:0] pin0();
    return {27'h0, pad_oe[0], pad_out[0], pu[0], pd[0], ibe[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #50000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    go(1);
    ck("pads after reset", '0, pad_oe | pu | pd | ibe);
    wr(8'h04, 32'hff);
    wr(8'h05, 32'hff);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h02, {29'h0, rows[i][8:6]});
      wr(8'h00, {31'h0, rows[i][5]});
      go(1);
      ck("pin0 drive", {27'h0, rows[i][4:0]}, pin0());
    end
    wr(8'h05, 32'h0);
    go(1);
    ck("output buffer off", 32'h1, pin0());
    wr(8'h13, 32'ha5);
    wr(8'h06, 32'h3c);
    go(1);
    ck("threshold", 32'ha5, {24'h0, thr[15:8]});
    ck("slew", 32'h3c, {24'h0, slew[7:0]});
    ext_val <= 32'hff00005a;
    wr(8'h02, 32'h249249);
    wr(8'h01, 32'hff);
    go(3);
    rd(8'h01, 32'h5a);
    wr(8'h0a, 32'h5);
    wr(8'h0c, 32'h1);
    go(3);
    rd(8'h01, 32'h5b);
    rd(8'h41, 32'h0);
    rd(8'h0d, 32'h0);
    wr(8'h32, 32'h249249);
    wr(8'h34, 32'hff);
    go(3);
    rd(8'h31, 32'h0f);
    wr(8'h02, 32'h30);
    wr(8'h05, 32'h2);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h07, {28'h0, 2'(c), 2'h0});
      go(3);
      ck("mux out", {31'h0, c[0]}, {31'h0, pad_out[1]});
      ck("mux in", {31'h0, c[0]}, {31'h0, periph_in[1]});
    end
    // Pin 1 now carries a one from source c; an all-zero outbound table must turn it to zero.
    wr(8'h0c, 32'h201);
    go(1);
    ck("lut out", 32'h0, {31'h0, pad_out[1]});
    wr(8'h12, 32'h249249);
    wr(8'h14, 32'hff);
    wr(8'h18, 32'hff);
    wr(8'h19, 32'h2);
    ext_val[10] <= 1'b1;
    go(4);
    ck("irq masked pin", 32'h0, {28'h0, irq});
    ext_val[9] <= 1'b1;
    go(4);
    ck("irq raised", 32'h2, {28'h0, irq});
    ext_val[9] <= 1'b0;
    go(4);
    rd(8'h18, 32'h2);
    ck("irq sticky", 32'h2, {28'h0, irq});
    wr(8'h18, 32'h2);
    go(1);
    ck("irq cleared", 32'h0, {28'h0, irq});
    ext_val[9] <= 1'b1;
    go(4);
    wr(8'h19, 32'h0);
    go(1);
    ck("irq disabled", 32'h0, {28'h0, irq});
    rd(8'h18, 32'h2);
    @(posedge clk);
    srst <= 1'b1;
    go(2);
    ck("pads in reset", '0, pad_oe | pu | pd | ibe);
    ck("irq in reset", 32'h0, {28'h0, irq});
    @(posedge clk);
    srst <= 1'b0;
    rd(8'h02, 32'h0);
    rd(8'h14, 32'h0);
    close_out();
  end
endmodule // gpio_port_with_pin_logic_tb
